/* pcibr_chk.sv */
// Checker for the PCI bridge block, bound to pcibr_top.
// Assumes mclk is the only domain and reset_n is async active low.
`timescale 1ns/1ps
`include "pcibr_defines.vh"
module pcibr_chk #(
   parameter AW = 8
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Register bus
   input wire logic pp_wr,
   input wire logic [1:0] pp_size,
   input wire logic [AW-1:0] pp_addr,
   input wire logic [31:0] pp_rdata_r,
   input wire logic pp_ack_r,
   // Master and target
   input wire logic pci_req_r,
   input wire logic [3:0] pci_cmd_r,
   input wire logic [31:0] pci_addr_r,
   input wire logic mst_reject_r,
   input wire logic tgt_accept_r,
   input wire logic [2:0] tgt_kind_r,
   // Mode
   input wire logic host_en_r,
   input wire logic bridge_en_r,
   input wire logic fb_clk_sel_r
);
   // ==========================================================
   // Edges since reset release; mode settles by the fifth
   logic [3:0] up_r;
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) up_r <= 4'h0;
      else if (up_r != 4'h8) up_r <= up_r + 4'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // Assertions
   chk_mode_hold: assert property (up_r == 4'h8 |-> $stable({host_en_r, bridge_en_r, fb_clk_sel_r}))
      else $error("mode changed after capture");
   chk_off_idle: assert property (up_r == 4'h8 && !bridge_en_r |-> !pci_req_r && !tgt_accept_r)
      else $error("disabled bridge is active");
   chk_fb_host: assert property (bridge_en_r && fb_clk_sel_r |-> host_en_r)
      else $error("feedback clock without host role");
   chk_host_cmd: assert property (pci_req_r && pci_cmd_r inside {`PCIBR_CMD_CFGRD,
      `PCIBR_CMD_CFGWR, `PCIBR_CMD_SPECIAL} |-> host_en_r)
      else $error("host-only command issued as non-host");
   chk_never_cmd: assert property (pci_req_r |-> !(pci_cmd_r inside {`PCIBR_CMD_INTACK,
      `PCIBR_CMD_RDMULT, `PCIBR_CMD_DAC, `PCIBR_CMD_RDLINE, `PCIBR_CMD_WRINV}))
      else $error("forbidden command issued");
   chk_req_steady: assert property (pci_req_r |-> $stable(pci_cmd_r) && $stable(pci_addr_r))
      else $error("cycle fields moved during request");
   chk_tgt_cfg: assert property (tgt_accept_r && tgt_kind_r inside {`PCIBR_KIND_CFGRD,
      `PCIBR_KIND_CFGWR} |-> !host_en_r)
      else $error("configuration accepted as host");
   chk_tgt_kind: assert property (tgt_accept_r |-> tgt_kind_r != `PCIBR_KIND_NONE
      && tgt_kind_r <= `PCIBR_KIND_CFGWR)
      else $error("accept with bad kind");
   chk_ack_pulse: assert property (pp_ack_r |=> !pp_ack_r)
      else $error("bus ack longer than one cycle");
   chk_bad_zero: assert property (pp_ack_r && !$past(pp_wr)
      && $past(pp_size) != `PCIBR_SIZE_LONG |-> pp_rdata_r == 32'h0)
      else $error("short read returned data");
   // ==========================================================
   // Coverage of main scenarios
   cov_cfg_rd: cover property ($rose(pci_req_r) && pci_cmd_r == `PCIBR_CMD_CFGRD);
   cov_tgt_cfg: cover property (tgt_accept_r && tgt_kind_r == `PCIBR_KIND_CFGWR);
   cov_reject: cover property (mst_reject_r);
endmodule // pcibr_chk

bind pcibr_top pcibr_chk #(.AW(AW)) i_chk (.mclk, .reset_n, .pp_wr, .pp_size, .pp_addr,
   .pp_rdata_r, .pp_ack_r, .pci_req_r, .pci_cmd_r, .pci_addr_r, .mst_reject_r, .tgt_accept_r,
   .tgt_kind_r, .host_en_r, .bridge_en_r, .fb_clk_sel_r);

/* pcibr_defines.vh */
// Constants for the PCI bridge configuration-PIO and mode-select block.
// Included by pcibr_top.v; holds definitions only.
`ifndef PCIBR_DEFINES_VH
`define PCIBR_DEFINES_VH

// ==========================================================
// Register offsets on the peripheral bus (byte addresses)
`define PCIBR_OFS_ADDR 8'h00
`define PCIBR_OFS_DATA 8'h04
`define PCIBR_OFS_MODE 8'h08

// ==========================================================
// Access size code for a full 32-bit longword
`define PCIBR_SIZE_LONG 2'b10

// ==========================================================
// Strap codes {host_role_strap, clock_source_strap}
`define PCIBR_MODE_HOST_EXT 2'b00
`define PCIBR_MODE_HOST_FB 2'b01
`define PCIBR_MODE_NHOST_EXT 2'b10
`define PCIBR_MODE_OFF 2'b11

// ==========================================================
// Status register bit positions
`define PCIBR_ST_HOST 0
`define PCIBR_ST_FBCLK 1
`define PCIBR_ST_OFF 2
`define PCIBR_ST_VALID 3
`define PCIBR_ST_BUSY 4
`define PCIBR_ST_PAD 27'h0000000

// ==========================================================
// PCI bus command codes
`define PCIBR_CMD_INTACK 4'h0
`define PCIBR_CMD_SPECIAL 4'h1
`define PCIBR_CMD_IORD 4'h2
`define PCIBR_CMD_IOWR 4'h3
`define PCIBR_CMD_MEMRD 4'h6
`define PCIBR_CMD_MEMWR 4'h7
`define PCIBR_CMD_CFGRD 4'hA
`define PCIBR_CMD_CFGWR 4'hB
`define PCIBR_CMD_RDMULT 4'hC
`define PCIBR_CMD_DAC 4'hD
`define PCIBR_CMD_RDLINE 4'hE
`define PCIBR_CMD_WRINV 4'hF

// ==========================================================
// Target-side decoded command kinds
`define PCIBR_KIND_NONE 3'h0
`define PCIBR_KIND_MEMRD 3'h1
`define PCIBR_KIND_MEMWR 3'h2
`define PCIBR_KIND_IORD 3'h3
`define PCIBR_KIND_IOWR 3'h4
`define PCIBR_KIND_CFGRD 3'h5
`define PCIBR_KIND_CFGWR 3'h6

// ==========================================================
// Edges after reset release before the straps are read; the pin
// synchroniser needs four edges to carry a level through to its output
`define PCIBR_STRAP_SETTLE 3'h4

`endif

/* pcibr_eng_mdl.sv */
// Behavioural PCI engine beyond the bridge: answers master cycles.
// Assumes a four-phase req/ack handshake clocked by the PCI bus clock.
`timescale 1ns/1ps
module pcibr_eng_mdl (
   // PCI bus clock and answer delay
   input wire logic pclk,
   input wire logic [3:0] dly,
   // Master cycle request
   input wire logic req,
   input wire logic [3:0] cmd,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   // Answer
   output logic ack,
   output logic [31:0] rdata
);
   // ==========================================================
   // Cycle record read by the bench
   int cycles = 0;
   logic [3:0] last_cmd;
   logic [31:0] last_addr, last_wdata;
   initial begin
      ack = 1'b0;
      rdata = 32'h0;
   end
   // Four-phase answer; data is scrambled once released, never left stale
   always begin
      @(posedge req);
      repeat (dly) @(posedge pclk);
      cycles++;
      last_cmd = cmd;
      last_addr = addr;
      last_wdata = wdata;
      rdata = 32'h5A5A1234;
      ack = 1'b1;
      wait (!req);
      @(posedge pclk);
      ack = 1'b0;
      rdata = ~rdata; // Released bus
   end
endmodule // pcibr_eng_mdl

/* pcibr_sync.v */
// Three-stage synchroniser for pins from outside the mclk domain.
// Assumes each bit is independent; output moves only when stages two
// and three agree, which filters single-sample glitches.
`timescale 1ns/1ps

module pcibr_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire mclk,
   input wire reset_n,
   // Raw and settled levels
   input wire [W-1:0] din,
   output reg [W-1:0] dout_r
);

   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;

   // ==========================================================
   // Stages; s1 feeds only s2 to keep metastability contained
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
         dout_r <= {W{1'b0}};
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         dout_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & dout_r);
      end
   end

endmodule // pcibr_sync

/* pcibr_top.v */
// PCI bridge: configuration PIO data register, strap mode select,
// master command gating and target command decoding.
// Assumes the peripheral bus holds a request until acked, and that the
// PCI engine beyond answers pci_req with a four-phase pci_ack.
`timescale 1ns/1ps
`include "pcibr_defines.vh"

// Functional notes
// - The configuration data register is one 32-bit word, read and written from the peripheral bus.
// - The configuration data register has no reset value and is undefined until written.
// - As host, reading the data register runs a configuration read on PCI, writing runs a configuration write.
// - The two mode straps are captured as reset is released and held from then on.
// - Straps 0,0 select host role clocked from the external PCI clock input.
// - Straps 0,1 select host role clocked from the fed-back bus clock pin.
// - Straps 1,0 select non-host role clocked from the external PCI clock input.
// - Straps 1,1 disable the bridge so it performs no PCI operation.
// - As master it issues memory and I/O commands always, configuration and special only as host, never the others.
// - As target it takes memory and I/O always, configuration only as non-host, and read line or multiple as memory read.
// - As target write-and-invalidate acts as memory write, and special, interrupt ack and dual address are ignored.
// - Only 32-bit accesses are honoured; other sizes and unmapped offsets read zero and drop writes.
// - A peripheral bus read stalls until the requested data is really available.
module pcibr_top #(
   parameter AW = 8
) (
   // Clock and reset
   input wire mclk,
   input wire reset_n,
   // Peripheral register bus
   input wire pp_sel,
   input wire pp_wr,
   input wire [1:0] pp_size,
   input wire [AW-1:0] pp_addr,
   input wire [31:0] pp_wdata,
   output reg [31:0] pp_rdata_r,
   output reg pp_ack_r,
   // Mode straps and clock pins
   input wire host_role_strap,
   input wire clock_source_strap,
   input wire external_pci_clock_in,
   input wire bus_clock_feedback_pin,
   // Master cycle request to the PCI engine
   output reg pci_req_r,
   output reg [3:0] pci_cmd_r,
   output reg [31:0] pci_addr_r,
   output reg [31:0] pci_wdata_r,
   input wire pci_ack,
   input wire [31:0] pci_rdata,
   // Local master requests
   input wire mst_req,
   input wire [3:0] mst_cmd,
   input wire [31:0] mst_addr,
   input wire [31:0] mst_wdata,
   output reg mst_done_r,
   output reg mst_reject_r,
   output reg [31:0] mst_rdata_r,
   // Target command from the PCI bus
   input wire tgt_valid,
   input wire [3:0] tgt_cmd,
   output reg tgt_accept_r,
   output reg [2:0] tgt_kind_r,
   // Mode outputs
   output reg host_en_r,
   output reg bridge_en_r,
   output reg fb_clk_sel_r
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ARM = 3'h1;
   localparam [2:0] ST_REQ = 3'h2;
   localparam [2:0] ST_REL = 3'h3;

   reg [2:0] state_r;
   reg src_pp_r;
   reg rd_r;
   reg [31:0] cfg_addr_r;
   reg [31:0] cfg_data_r;
   reg [2:0] settle_r;
   reg mode_valid_r;
   reg pclk_prev_r;
   reg tgt_prev_r;
   wire [5:0] sync_s;
   wire pclk_s;
   wire pclk_rise;
   wire ack_s;
   wire tgt_s;
   wire pp_go;
   wire size_ok;
   wire is_addr;
   wire is_data;
   wire is_mode;
   wire [31:0] status_w;
   wire [2:0] tgt_kind_w;

   // Master gate: memory and I/O always, config and special host only
   function mst_ok;
      input [3:0] cmd;
      input host;
      begin
         case (cmd)
            `PCIBR_CMD_MEMRD, `PCIBR_CMD_MEMWR,
            `PCIBR_CMD_IORD, `PCIBR_CMD_IOWR: mst_ok = 1'b1;
            `PCIBR_CMD_CFGRD, `PCIBR_CMD_CFGWR,
            `PCIBR_CMD_SPECIAL: mst_ok = host;
            default: mst_ok = 1'b0;
         endcase
      end
   endfunction

   // Target map: line and multiple fold into plain memory read
   function [2:0] tgt_map;
      input [3:0] cmd;
      input host;
      begin
         case (cmd)
            `PCIBR_CMD_MEMRD, `PCIBR_CMD_RDLINE,
            `PCIBR_CMD_RDMULT: tgt_map = `PCIBR_KIND_MEMRD;
            `PCIBR_CMD_MEMWR, `PCIBR_CMD_WRINV: tgt_map = `PCIBR_KIND_MEMWR;
            `PCIBR_CMD_IORD: tgt_map = `PCIBR_KIND_IORD;
            `PCIBR_CMD_IOWR: tgt_map = `PCIBR_KIND_IOWR;
            `PCIBR_CMD_CFGRD: tgt_map = host ? `PCIBR_KIND_NONE : `PCIBR_KIND_CFGRD;
            `PCIBR_CMD_CFGWR: tgt_map = host ? `PCIBR_KIND_NONE : `PCIBR_KIND_CFGWR;
            default: tgt_map = `PCIBR_KIND_NONE;
         endcase
      end
   endfunction

   // ==========================================================
   // Pin synchronisers
   pcibr_sync #(
      .W(6)
   ) u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .din({tgt_valid, pci_ack, host_role_strap, clock_source_strap,
            bus_clock_feedback_pin, external_pci_clock_in}),
      .dout_r(sync_s)
   );

   // Selected PCI bus clock and its rising edge
   assign pclk_s = fb_clk_sel_r ? sync_s[1] : sync_s[0];
   assign pclk_rise = pclk_s & ~pclk_prev_r;
   assign ack_s = sync_s[4];
   assign tgt_s = sync_s[5];

   // Access decode; disabled mode answers like an unmapped hole
   assign size_ok = (pp_size == `PCIBR_SIZE_LONG) & bridge_en_r;
   assign is_addr = size_ok & (pp_addr == `PCIBR_OFS_ADDR);
   assign is_data = size_ok & (pp_addr == `PCIBR_OFS_DATA);
   assign is_mode = size_ok & (pp_addr == `PCIBR_OFS_MODE);
   assign pp_go = pp_sel & ~pp_ack_r & mode_valid_r & (state_r == ST_IDLE);
   assign tgt_kind_w = tgt_map(tgt_cmd, host_en_r);

   // Status word shows the captured mode and the engine state
   assign status_w = {`PCIBR_ST_PAD, (state_r != ST_IDLE), mode_valid_r,
                      ~bridge_en_r, fb_clk_sel_r, host_en_r};

   // ==========================================================
   // Strap capture: waits for the synchronisers, then freezes mode
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         settle_r <= 3'h0;
         mode_valid_r <= 1'b0;
         host_en_r <= 1'b0;
         bridge_en_r <= 1'b0;
         fb_clk_sel_r <= 1'b0;
      end else if (!mode_valid_r) begin
         if (settle_r == `PCIBR_STRAP_SETTLE) begin
            mode_valid_r <= 1'b1;
            case ({sync_s[3], sync_s[2]})
               `PCIBR_MODE_HOST_EXT: begin
                  host_en_r <= 1'b1;
                  bridge_en_r <= 1'b1;
                  fb_clk_sel_r <= 1'b0;
               end
               `PCIBR_MODE_HOST_FB: begin
                  host_en_r <= 1'b1;
                  bridge_en_r <= 1'b1;
                  fb_clk_sel_r <= 1'b1;
               end
               `PCIBR_MODE_NHOST_EXT: begin
                  host_en_r <= 1'b0;
                  bridge_en_r <= 1'b1;
                  fb_clk_sel_r <= 1'b0;
               end
               default: begin
                  host_en_r <= 1'b0;
                  bridge_en_r <= 1'b0;
                  fb_clk_sel_r <= 1'b0;
               end
            endcase
         end else begin
            settle_r <= settle_r + 3'h1;
         end
      end
   end

   // ==========================================================
   // Data register: deliberately unreset, undefined until written
   always @(posedge mclk) begin
      if (pp_go && pp_wr && is_data) begin
         cfg_data_r <= pp_wdata;
      end else if (state_r == ST_REQ && ack_s && src_pp_r && rd_r) begin
         cfg_data_r <= pci_rdata;
      end
   end

   // ==========================================================
   // Bus slave and master cycle engine
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         src_pp_r <= 1'b0;
         rd_r <= 1'b0;
         cfg_addr_r <= 32'h00000000;
         pp_rdata_r <= 32'h00000000;
         pp_ack_r <= 1'b0;
         pci_req_r <= 1'b0;
         pci_cmd_r <= 4'h0;
         pci_addr_r <= 32'h00000000;
         pci_wdata_r <= 32'h00000000;
         mst_done_r <= 1'b0;
         mst_reject_r <= 1'b0;
         mst_rdata_r <= 32'h00000000;
         pclk_prev_r <= 1'b0;
      end else begin
         pp_ack_r <= 1'b0;
         mst_done_r <= 1'b0;
         mst_reject_r <= 1'b0;
         pclk_prev_r <= pclk_s;
         case (state_r)
            ST_IDLE: begin
               if (pp_go) begin
                  src_pp_r <= 1'b1;
                  rd_r <= ~pp_wr;
                  pp_rdata_r <= 32'h00000000;
                  if (is_data && mst_ok(`PCIBR_CMD_CFGRD, host_en_r)) begin
                     // Config cycle; reads hold ack back until data lands
                     state_r <= ST_ARM;
                     pci_cmd_r <= pp_wr ? `PCIBR_CMD_CFGWR : `PCIBR_CMD_CFGRD;
                     pci_addr_r <= cfg_addr_r;
                     pci_wdata_r <= pp_wdata;
                     pp_ack_r <= pp_wr;
                  end else begin
                     pp_ack_r <= 1'b1;
                     if (is_addr && pp_wr) begin
                        cfg_addr_r <= pp_wdata;
                     end
                     if (!pp_wr && is_addr) begin
                        pp_rdata_r <= cfg_addr_r;
                     end
                     if (!pp_wr && is_data) begin
                        pp_rdata_r <= cfg_data_r;
                     end
                     if (!pp_wr && is_mode) begin
                        pp_rdata_r <= status_w;
                     end
                  end
               end else if (mst_req && mode_valid_r) begin
                  src_pp_r <= 1'b0;
                  rd_r <= ~mst_cmd[0];
                  if (bridge_en_r && mst_ok(mst_cmd, host_en_r)) begin
                     state_r <= ST_ARM;
                     pci_cmd_r <= mst_cmd;
                     pci_addr_r <= mst_addr;
                     pci_wdata_r <= mst_wdata;
                  end else begin
                     mst_reject_r <= 1'b1;
                  end
               end
            end
            ST_ARM: begin
               // Launch aligned to a PCI clock rising edge
               if (pclk_rise) begin
                  pci_req_r <= 1'b1;
                  state_r <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (ack_s) begin
                  pci_req_r <= 1'b0;
                  pp_rdata_r <= pci_rdata;
                  mst_rdata_r <= pci_rdata;
                  state_r <= ST_REL;
               end
            end
            ST_REL: begin
               // Four-phase close; engine must drop ack before reuse
               if (!ack_s) begin
                  state_r <= ST_IDLE;
                  pp_ack_r <= src_pp_r & rd_r;
                  mst_done_r <= ~src_pp_r;
               end
            end
            default: begin
               state_r <= ST_IDLE;
               pci_req_r <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Target command decode on each new valid
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tgt_prev_r <= 1'b0;
         tgt_accept_r <= 1'b0;
         tgt_kind_r <= `PCIBR_KIND_NONE;
      end else begin
         tgt_prev_r <= tgt_s;
         tgt_accept_r <= 1'b0;
         if (tgt_s && !tgt_prev_r && bridge_en_r) begin
            tgt_kind_r <= tgt_kind_w;
            tgt_accept_r <= (tgt_kind_w != `PCIBR_KIND_NONE);
         end
      end
   end

endmodule // pcibr_top

/* tb_top.sv */
// Self-checking bench for the PCI bridge configuration PIO and straps.
// Assumes the engine model, checker and design files compile first.
`timescale 1ns/1ps
`include "pcibr_defines.vh"
module tb_top;
   // ==========================================================
   // Signals and clocks
   logic mclk = 0, pclk = 0, fbclk = 0, ext_run = 1, reset_n = 0, pp_sel = 0, pp_wr = 0;
   logic host_role_strap = 0, clock_source_strap = 0, pci_req_r, pci_ack, pp_ack_r;
   logic mst_req = 0, mst_done_r, mst_reject_r, tgt_valid = 0, tgt_accept_r;
   logic host_en_r, bridge_en_r, fb_clk_sel_r;
   logic [1:0] pp_size = 0;
   logic [7:0] pp_addr = 0;
   logic [31:0] pp_wdata = 0, pp_rdata_r, pci_addr_r, pci_wdata_r, pci_rdata, r;
   logic [31:0] mst_addr = 0, mst_wdata = 0, mst_rdata_r;
   logic [3:0] pci_cmd_r, mst_cmd = 0, tgt_cmd = 0, eng_dly = 4'h2;
   logic [2:0] tgt_kind_r;
   int miscompares = 0, comparisons = 0, cyc = 0;
   initial forever #2.5 mclk = ~mclk;
   always #32 if (ext_run) pclk = ~pclk; // Stopped to prove feedback clock use
   always #27 fbclk = ~fbclk;
   pcibr_top i_dut (.mclk, .reset_n, .pp_sel, .pp_wr, .pp_size, .pp_addr, .pp_wdata,
      .pp_rdata_r, .pp_ack_r, .host_role_strap, .clock_source_strap,
      .external_pci_clock_in(pclk), .bus_clock_feedback_pin(fbclk), .pci_req_r, .pci_cmd_r,
      .pci_addr_r, .pci_wdata_r, .pci_ack, .pci_rdata, .mst_req, .mst_cmd, .mst_addr,
      .mst_wdata, .mst_done_r, .mst_reject_r, .mst_rdata_r, .tgt_valid, .tgt_cmd,
      .tgt_accept_r, .tgt_kind_r, .host_en_r, .bridge_en_r, .fb_clk_sel_r);
   pcibr_eng_mdl i_eng (.pclk(ext_run ? pclk : fbclk), .dly(eng_dly), .req(pci_req_r),
      .cmd(pci_cmd_r), .addr(pci_addr_r), .wdata(pci_wdata_r), .ack(pci_ack), .rdata(pci_rdata));
   // Hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         final_report;
      end
   end
   // ==========================================================
   // Shared tasks
   task final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Straps set during reset, then flipped to prove they are held
   task do_reset(input logic [1:0] m, input logic [2:0] e);
      @(negedge mclk);
      reset_n = 0;
      {host_role_strap, clock_source_strap} = m;
      repeat (5) @(negedge mclk);
      reset_n = 1;
      repeat (8) @(negedge mclk);
      {host_role_strap, clock_source_strap} = ~m;
      repeat (8) @(negedge mclk);
      chk("mode", {host_en_r, bridge_en_r, fb_clk_sel_r}, e);
   endtask
   // Request held past the rising edge that samples ack, then released
   task bus(input logic w, input logic [1:0] sz, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(negedge mclk);
      {pp_sel, pp_wr, pp_size, pp_addr, pp_wdata} = {1'b1, w, sz, a, d};
      do @(negedge mclk); while (pp_ack_r !== 1'b1 && ++k < 3000);
      r = pp_rdata_r;
      chk("pp_ack", pp_ack_r, 1);
      @(negedge mclk);
      pp_sel = 0;
   endtask
   // ==========================================================
   // Scenarios
   task t_cfg_host;
      int n;
      bus(1, `PCIBR_SIZE_LONG, `PCIBR_OFS_ADDR, 32'h00001234);
      bus(1, `PCIBR_SIZE_LONG, `PCIBR_OFS_DATA, 32'hCAFE0001);
      bus(0, `PCIBR_SIZE_LONG, `PCIBR_OFS_ADDR, 0);
      chk("cfgwr_cmd", i_eng.last_cmd, `PCIBR_CMD_CFGWR);
      chk("cfgwr_data", i_eng.last_wdata, 32'hCAFE0001);
      chk("cfg_addr", i_eng.last_addr, 32'h00001234);
      eng_dly = 4'h7; // Slow engine: read must wait for it
      n = i_eng.cycles;
      bus(0, `PCIBR_SIZE_LONG, `PCIBR_OFS_DATA, 0);
      chk("cfgrd_data", r, 32'h5A5A1234);
      chk("cfgrd_cmd", i_eng.last_cmd, `PCIBR_CMD_CFGRD);
      chk("cfgrd_count", i_eng.cycles - n, 1);
      eng_dly = 4'h2;
   endtask
   task t_refuse;
      int n;
      n = i_eng.cycles;
      bus(0, 2'b01, `PCIBR_OFS_DATA, 0);
      chk("short_rd", r, 0);
      bus(1, 2'b00, `PCIBR_OFS_ADDR, 32'hFFFFFFFF);
      bus(0, `PCIBR_SIZE_LONG, 8'h40, 0);
      chk("unmapped_rd", r, 0);
      bus(0, `PCIBR_SIZE_LONG, `PCIBR_OFS_ADDR, 0);
      chk("short_wr_dropped", r, 32'h00001234);
      bus(0, `PCIBR_SIZE_LONG, `PCIBR_OFS_MODE, 0);
      chk("status", r, 32'h00000009);
      chk("no_cycle", i_eng.cycles - n, 0);
   endtask
   task t_reg_nonhost;
      int n;
      n = i_eng.cycles;
      bus(1, `PCIBR_SIZE_LONG, `PCIBR_OFS_DATA, 32'hA5C30FF0);
      bus(0, `PCIBR_SIZE_LONG, `PCIBR_OFS_DATA, 0);
      chk("data_rw", r, 32'hA5C30FF0);
      chk("nonhost_no_cycle", i_eng.cycles - n, 0);
   endtask
   task t_master(input logic h, input logic en);
      int n, k;
      logic ok;
      for (int c = 0; c < 16; c++) begin
         ok = en && (c inside {2, 3, 6, 7} || (h && c inside {1, 10, 11}));
         n = i_eng.cycles;
         k = 0;
         repeat (4) @(negedge mclk);
         {mst_req, mst_cmd, mst_addr} = {1'b1, 4'(c), 32'(c)};
         @(negedge mclk);
         mst_req = 0;
         while (mst_done_r !== 1'b1 && mst_reject_r !== 1'b1 && ++k < 3000) @(negedge mclk);
         chk("mst_reject", mst_reject_r, !ok);
         chk("mst_cycles", i_eng.cycles - n, ok);
         if (ok) chk("mst_cmd", i_eng.last_cmd, c);
         if (ok) chk("mst_addr", i_eng.last_addr, c);
         if (ok && c % 2 == 0) chk("mst_rdata", mst_rdata_r, 32'h5A5A1234);
      end
   endtask
   task t_target(input logic h);
      logic acc;
      logic [2:0] k;
      for (int c = 0; c < 16; c++) begin
         case (c)
            6, 12, 14: k = `PCIBR_KIND_MEMRD;
            7, 15: k = `PCIBR_KIND_MEMWR;
            2: k = `PCIBR_KIND_IORD;
            3: k = `PCIBR_KIND_IOWR;
            10: k = h ? `PCIBR_KIND_NONE : `PCIBR_KIND_CFGRD;
            11: k = h ? `PCIBR_KIND_NONE : `PCIBR_KIND_CFGWR;
            default: k = `PCIBR_KIND_NONE;
         endcase
         @(negedge mclk);
         {tgt_valid, tgt_cmd, acc} = {1'b1, 4'(c), 1'b0};
         repeat (8) begin
            @(negedge mclk);
            acc = acc | tgt_accept_r;
         end
         chk("tgt_kind", tgt_kind_r, k);
         chk("tgt_accept", acc, k != 0);
         tgt_valid = 0;
         repeat (6) @(negedge mclk);
      end
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      do_reset(2'b00, 3'b110);
      t_cfg_host;
      t_refuse;
      t_master(1, 1);
      t_target(1);
      ext_run = 0;
      do_reset(2'b01, 3'b111);
      t_cfg_host;
      ext_run = 1;
      do_reset(2'b10, 3'b010);
      t_reg_nonhost;
      t_master(0, 1);
      t_target(0);
      do_reset(2'b11, 3'b000);
      t_master(0, 0);
      final_report;
   end
endmodule // tb_top
